// ===== rtl/fdec_host.sv
`timescale 1ns/1ps
module fdec_host #(
  parameter int NDEV = 3,  // chain length, any depth
  parameter int DW   = 9   // data width, wider for parallel devices
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output fdec_pkg::fdec_pins_s    fifo_ctl,
  output logic      [DW-1:0]      fifo_wdata,
  output logic      [NDEV-1:0]    first_load_or_retransmit_n,
  input  wire logic [DW-1:0]      fifo_rdata,
  input  wire logic [NDEV-1:0]    full_flag_n,
  input  wire logic [NDEV-1:0]    empty_flag_n
);

  fdec_pkg::fdec_state_e st_q, st_d;
  fdec_pkg::fdec_op_e    op_q, op_go;
  logic [3:0]            cnt_q, cnt_d;
  logic                  depth_q, mode_q, init_q, err_q;
  logic [DW-1:0]         rdata_q;

  // apb decode
  wire acc       = psel & penable;
  wire hit_ctrl  = paddr == fdec_pkg::CTRL_OFF;
  wire hit_wdata = paddr == fdec_pkg::WDATA_OFF;
  wire hit_rdata = paddr == fdec_pkg::RDATA_OFF;
  wire hit_stat  = paddr == fdec_pkg::STAT_OFF;
  wire unmapped  = ~(hit_ctrl | hit_wdata | hit_rdata | hit_stat);
  wire rst_cmd   = hit_ctrl & pwdata[fdec_pkg::CTRL_RESET_BIT];
  wire retx_cmd  = hit_ctrl & pwdata[fdec_pkg::CTRL_RETX_BIT];
  wire cmd_acc   = acc & pwrite & (hit_wdata | hit_rdata | rst_cmd | retx_cmd);
  wire busy      = st_q != fdec_pkg::ST_IDLE;
  assign pready  = ~(cmd_acc & busy);
  wire wr_ok     = acc & pready & pwrite;
  assign pslverr = acc & pready & unmapped;

  // composite flags: every chained device must agree; otherwise device 0 alone
  // is trusted, flags of parallel devices are never combined
  // relies on the chain being wired out-to-in on the board
  wire comp_full_n  = mode_q ? |full_flag_n  : full_flag_n[0];
  wire comp_empty_n = mode_q ? |empty_flag_n : empty_flag_n[0];

  // writer is gated by full, reader by empty
  wire wr_req   = cmd_acc & ~busy & hit_wdata;
  wire rd_req   = cmd_acc & ~busy & hit_rdata;
  wire rst_req  = cmd_acc & ~busy & rst_cmd;
  wire retx_req = cmd_acc & ~busy & retx_cmd & ~rst_cmd;
  wire wr_go    = wr_req & init_q & comp_full_n;
  wire rd_go    = rd_req & init_q & comp_empty_n;
  // retransmit is refused while the chain runs in depth operation
  wire retx_go  = retx_req & init_q & ~mode_q;
  wire go       = wr_go | rd_go | retx_go | rst_req;
  wire refuse   = (wr_req | rd_req | retx_req) & ~go;

  always_comb begin
    if (rst_req) begin
      op_go = fdec_pkg::OP_RST;
    end else if (retx_req) begin
      op_go = fdec_pkg::OP_RETX;
    end else if (rd_req) begin
      op_go = fdec_pkg::OP_RD;
    end else begin
      op_go = fdec_pkg::OP_WR;
    end
  end

  wire retx_op = op_q == fdec_pkg::OP_RETX;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end else begin
      case (st_q)
        fdec_pkg::ST_IDLE: begin
          if (go && op_go == fdec_pkg::OP_RST) begin
            st_d  = fdec_pkg::ST_RST;
            cnt_d = 4'(fdec_pkg::RESET_CYC - 1);
          end else if (go) begin
            st_d  = fdec_pkg::ST_SETUP;
            cnt_d = 4'(fdec_pkg::DSETUP_CYC - 1);
          end
        end
        fdec_pkg::ST_SETUP: begin
          st_d  = fdec_pkg::ST_LOW;
          cnt_d = retx_op ? 4'(fdec_pkg::RETX_CYC - 1) : 4'(fdec_pkg::STROBE_CYC - 1);
        end
        fdec_pkg::ST_LOW: begin
          st_d  = fdec_pkg::ST_REC;
          cnt_d = 4'(fdec_pkg::RECOVER_CYC - 1);
        end
        fdec_pkg::ST_RST: begin
          st_d  = fdec_pkg::ST_SETTLE;
          cnt_d = 4'(fdec_pkg::SETTLE_CYC - 1);
        end
        default: begin
          st_d  = fdec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  wire low_st   = st_q == fdec_pkg::ST_LOW;
  wire rst_st   = st_q == fdec_pkg::ST_RST;
  wire rd_last  = low_st & (op_q == fdec_pkg::OP_RD) & (cnt_q == 4'h0);
  wire init_end = (st_q == fdec_pkg::ST_SETTLE) & (cnt_q == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= fdec_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      op_q  <= fdec_pkg::OP_WR;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      if (go) begin
        op_q <= op_go;
      end
    end
  end

  // mode is only adopted by a reset of the chain, as the devices do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= fdec_pkg::CTRL_DEPTH_RST;
      mode_q  <= fdec_pkg::CTRL_DEPTH_RST;
      init_q  <= 1'b0;
    end else begin
      if (wr_ok && hit_ctrl) begin
        depth_q <= pwdata[fdec_pkg::CTRL_DEPTH_BIT];
      end
      if (rst_req) begin
        mode_q <= depth_q;
        init_q <= 1'b0;
      end else if (init_end) begin
        init_q <= 1'b1;
      end
    end
  end

  // a fresh refusal beats a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (refuse) begin
      err_q <= 1'b1;
    end else if (wr_ok && hit_stat && pwdata[fdec_pkg::STAT_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_wdata <= '0;
      rdata_q    <= '0;
    end else begin
      if (wr_go) begin
        fifo_wdata <= pwdata[DW-1:0];
      end
      // sampled in the last low cycle, well past access time
      if (rd_last) begin
        rdata_q <= fifo_rdata;
      end
    end
  end

  // strobes stay high through the whole reset and settle time
  assign fifo_ctl.reset_n = ~rst_st;
  assign fifo_ctl.write_n = ~(low_st & (op_q == fdec_pkg::OP_WR));
  assign fifo_ctl.read_n  = ~(low_st & (op_q == fdec_pkg::OP_RD));

  // head low while reset in depth operation and during a retransmit pulse; chain-in is never driven
  // from here, neighbours alone time it
  genvar gi;
  generate
    for (gi = 0; gi < NDEV; gi++) begin : g_fl
      if (gi == 0) begin : g_head
        // applied mode, so a control write during reset cannot glitch the head
        assign first_load_or_retransmit_n[gi] =
          ~((rst_st & mode_q) | (low_st & retx_op));
      end else begin : g_tail
        assign first_load_or_retransmit_n[gi] = 1'b1;
      end
    end
  endgenerate

  wire [31:0] stat_word = 32'({mode_q, err_q, init_q, ~comp_empty_n, ~comp_full_n, busy});

  always_comb begin
    prdata = 32'h0;
    if (acc && !pwrite) begin
      if (hit_ctrl) begin
        prdata = 32'(depth_q);
      end else if (hit_wdata) begin
        prdata = 32'(fifo_wdata);
      end else if (hit_rdata) begin
        prdata = 32'(rdata_q);
      end else if (hit_stat) begin
        prdata = stat_word;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire [NDEV-1:0] fl_mask = {{(NDEV-1){1'b1}}, 1'b0};

  property p_head_fl;
    !fifo_ctl.reset_n && mode_q |-> !first_load_or_retransmit_n[0];
  endproperty
  a_head_fl: assert property (p_head_fl) else $error("head not first-load");

  property p_tail_fl;
    !fifo_ctl.reset_n |-> &(first_load_or_retransmit_n | ~fl_mask);
  endproperty
  a_tail_fl: assert property (p_tail_fl) else $error("tail first-load low");

  property p_no_retx_depth;
    init_q && mode_q |-> &first_load_or_retransmit_n;
  endproperty
  a_no_retx_depth: assert property (p_no_retx_depth) else $error("retx in depth");

  property p_retx_refused;
    retx_req && mode_q |=> err_q && !busy;
  endproperty
  a_retx_refused: assert property (p_retx_refused) else $error("retx not refused");

  property p_full_blocks;
    wr_req && !comp_full_n |=> err_q ##0 fifo_ctl.write_n [*4];
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("write while full");

  property p_empty_blocks;
    rd_req && init_q && !comp_empty_n |=> err_q ##0 fifo_ctl.read_n [*4];
  endproperty
  a_empty_blocks: assert property (p_empty_blocks) else $error("read while empty");

  property p_write_pulse;
    wr_go |-> fifo_ctl.write_n ##1 fifo_ctl.write_n ##1 !fifo_ctl.write_n [*2]
      ##1 fifo_ctl.write_n;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write pulse shape");

  property p_reset_seq;
    rst_req |=> !fifo_ctl.reset_n [*2] ##1 (fifo_ctl.reset_n && !init_q) [*3] ##1 init_q;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sequence");

  property p_strobes_in_reset;
    !fifo_ctl.reset_n || !init_q |-> fifo_ctl.write_n && fifo_ctl.read_n;
  endproperty
  a_strobes_in_reset: assert property (p_strobes_in_reset) else $error("strobe in reset");

  property p_wdata_hold;
    !fifo_ctl.write_n |-> $stable(fifo_wdata);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("data moved in write");

  c_write: cover property (wr_go ##5 !busy);
  c_read: cover property (rd_go ##3 rd_last);
  c_depth_reset: cover property (rst_req && depth_q ##6 init_q);
  c_retx: cover property (retx_go ##2 !first_load_or_retransmit_n[0]);

endmodule : fdec_host

// ===== rtl/fdec_pkg.sv
package fdec_pkg;

  localparam int CLK_MHZ = 10;

  // pin timing figures (slowest grade) and their cycle counts
  localparam int STROBE_NS       = 200;
  localparam int STROBE_CYC      = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int DSETUP_NS       = 65;
  localparam int DSETUP_CYC      = (DSETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_NS      = 35;
  localparam int RECOVER_CYC     = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_NS        = 200;
  localparam int RESET_CYC       = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_NS       = 235;
  localparam int SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int RETX_NS         = 200;
  localparam int RETX_CYC        = (RETX_NS * CLK_MHZ + 999) / 1000;

  // register map
  localparam logic [11:0] CTRL_OFF  = 12'h000;
  localparam logic [11:0] WDATA_OFF = 12'h004;
  localparam logic [11:0] RDATA_OFF = 12'h008;
  localparam logic [11:0] STAT_OFF  = 12'h00c;

  localparam int CTRL_DEPTH_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int CTRL_RETX_BIT  = 2;
  localparam logic CTRL_DEPTH_RST = 1'b0;

  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_READY_BIT = 3;
  localparam int STAT_ERR_BIT   = 4;
  localparam int STAT_MODE_BIT  = 5;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_LOW    = 3'h3,
    ST_REC    = 3'h2,
    ST_RST    = 3'h6,
    ST_SETTLE = 3'h7
  } fdec_state_e;

  typedef enum logic [1:0] {
    OP_WR   = 2'h0,
    OP_RD   = 2'h1,
    OP_RETX = 2'h2,
    OP_RST  = 2'h3
  } fdec_op_e;

  typedef struct packed {
    logic reset_n;
    logic write_n;
    logic read_n;
  } fdec_pins_s;

endpackage : fdec_pkg

// ===== test/fdec_chain_model.sv
`timescale 1ns/1ps
module fdec_chain_model #(
  parameter int NDEV  = 3,
  parameter int DEPTH = 4
) (
  input  wire fdec_pkg::fdec_pins_s ctl,
  input  wire logic [8:0]           wdata,
  input  wire logic [NDEV-1:0]      fl_n,
  output logic      [8:0]           rdata,
  output logic      [NDEV-1:0]      full_n,
  output logic      [NDEV-1:0]      empty_n
);
  logic [8:0] mem [NDEV][DEPTH];
  int         wp [NDEV];
  int         rp [NDEV];
  int         cnt [NDEV];
  int         wtok;
  int         rtok;
  bit         chain;
  bit         in_rst;
  bit         up;

  initial rdata = 9'h0aa;

  // sticky first-load sample: the pin may rise in the same step as reset
  always @(ctl.reset_n or fl_n[0]) begin
    if (ctl.reset_n === 1'b0) begin
      if (!in_rst) begin
        wtok  = 0;
        rtok  = 0;
        chain = 1'b0;
        foreach (wp[i]) begin
          wp[i]  = 0;
          rp[i]  = 0;
          cnt[i] = 0;
        end
      end
      in_rst = 1'b1;
      up     = 1'b1;
      chain  = chain | !fl_n[0];
    end else begin
      in_rst = 1'b0;
    end
  end

  always @(posedge ctl.write_n) begin
    if (up && ctl.reset_n && cnt[wtok] < DEPTH) begin
      mem[wtok][wp[wtok]] = wdata;
      cnt[wtok]++;
      wp[wtok] = (wp[wtok] + 1) % DEPTH;
      if (chain && wp[wtok] == 0) wtok = (wtok + 1) % NDEV;
    end
  end

  always @(negedge ctl.read_n) begin
    if (up && ctl.reset_n && cnt[rtok] > 0) begin
      rdata = mem[rtok][rp[rtok]];
      cnt[rtok]--;
      rp[rtok] = (rp[rtok] + 1) % DEPTH;
      if (chain && rp[rtok] == 0) rtok = (rtok + 1) % NDEV;
    end
  end

  // bus released after a read: never leave a stale copy
  always @(posedge ctl.read_n) rdata = ~rdata;

  // rewind read pointer only; no rewind in a chain
  always @(negedge fl_n[0]) begin
    if (up && ctl.reset_n && !chain) begin
      rp[0]  = 0;
      cnt[0] = wp[0];
    end
  end

  always_comb begin
    foreach (cnt[i]) begin
      empty_n[i] = cnt[i] != 0;
      full_n[i]  = cnt[i] != DEPTH;
    end
  end
endmodule : fdec_chain_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rv;
  logic [8:0]           wdata, rdata;
  logic [2:0]           fl_n, full_n, empty_n, fl_rst;
  fdec_pkg::fdec_pins_s ctl;
  int                   n_mismatch, total_checks, n_wr, n_rt;

  fdec_host #(.NDEV(3), .DW(9)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_ctl(ctl), .fifo_wdata(wdata),
    .first_load_or_retransmit_n(fl_n), .fifo_rdata(rdata), .full_flag_n(full_n),
    .empty_flag_n(empty_n));
  fdec_chain_model #(.NDEV(3), .DEPTH(4)) model_u (.ctl(ctl), .wdata(wdata), .fl_n(fl_n),
    .rdata(rdata), .full_n(full_n), .empty_n(empty_n));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(negedge ctl.write_n) n_wr++;
  // reset low and head first-load low fall in one step; let both settle first
  always @(negedge fl_n[0]) #1 if (ctl.reset_n === 1'b1) n_rt++;
  always @(negedge pclk) if (ctl.reset_n === 1'b0) fl_rst <= fl_n;

  task automatic check(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, s, x);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) check(0, 1);
    rv = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, fdec_pkg::STAT_OFF, 0);
      n++;
    end while (rv[0] !== 1'b0 && n < 20);
    if (rv[0] !== 1'b0) check(0, 1);
  endtask : wait_idle

  task automatic sc(input logic [5:0] x);
    wait_idle();
    check(rv[5:0], x);
  endtask : sc

  task automatic pop(input logic [8:0] x);
    apb(1'b1, fdec_pkg::RDATA_OFF, 0);
    wait_idle();
    check(rv[4], 0);
    apb(1'b0, fdec_pkg::RDATA_OFF, 0);
    check(rv[8:0], x);
  endtask : pop

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial begin
    #(5000 * 100);
    n_mismatch++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fdec_pkg::CTRL_OFF, 0);
    check(rv, 0);
    sc(6'h04);
    apb(1'b1, fdec_pkg::WDATA_OFF, 32'h1a5);
    sc(6'h14);
    check(n_wr, 0);
    apb(1'b1, fdec_pkg::STAT_OFF, 32'h10);
    sc(6'h04);
    apb(1'b0, 12'h010, 0);
    check(e, 1);
    $display("test reset done");
    apb(1'b1, fdec_pkg::CTRL_OFF, 32'h2);
    sc(6'h0c);
    check(fl_rst, 3'b111);
    apb(1'b1, fdec_pkg::WDATA_OFF, 32'h1a5);
    apb(1'b1, fdec_pkg::WDATA_OFF, 32'h0ff);
    apb(1'b1, fdec_pkg::WDATA_OFF, 32'h100);
    sc(6'h08);
    check(n_wr, 3);
    pop(9'h1a5);
    apb(1'b1, fdec_pkg::CTRL_OFF, 32'h4);
    pop(9'h1a5);
    pop(9'h0ff);
    pop(9'h100);
    sc(6'h0c);
    check(n_rt, 1);
    apb(1'b1, fdec_pkg::RDATA_OFF, 0);
    sc(6'h1c);
    apb(1'b1, fdec_pkg::STAT_OFF, 32'h10);
    $display("test standalone done");
    apb(1'b1, fdec_pkg::CTRL_OFF, 32'h1);
    apb(1'b1, fdec_pkg::CTRL_OFF, 32'h3);
    sc(6'h2c);
    check(fl_rst, 3'b110);
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, fdec_pkg::WDATA_OFF, 32'(i * 41 + 3));
      if (i == 4) sc(6'h28);
    end
    sc(6'h2a);
    apb(1'b1, fdec_pkg::WDATA_OFF, 32'h77);
    sc(6'h3a);
    check(n_wr, 15);
    apb(1'b1, fdec_pkg::STAT_OFF, 32'h10);
    apb(1'b1, fdec_pkg::CTRL_OFF, 32'h5);
    sc(6'h3a);
    check(n_rt, 1);
    apb(1'b1, fdec_pkg::STAT_OFF, 32'h10);
    for (int i = 0; i < 12; i++) pop(9'(i * 41 + 3));
    sc(6'h2c);
    $display("test depth done");
    test_done();
  end
endmodule : tb_top
